/* rtl/pwr_rst_pkg.sv */
package pwr_rst_pkg;

	// Clock and machine-cycle timing
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned CLKS_PER_MCYC = 4;
	localparam int unsigned RST_STRETCH_MCYC = 2;
	localparam int unsigned WDT_HOLD_MCYC = 2;
	localparam int unsigned WDT_RESET_DELAY_CLKS = 512;
	localparam int unsigned HOLD_W = 8;
	localparam logic [HOLD_W-1:0] RST_STRETCH_CLKS = HOLD_W'(RST_STRETCH_MCYC * CLKS_PER_MCYC);
	localparam logic [HOLD_W-1:0] WDT_HOLD_CLKS = HOLD_W'(WDT_HOLD_MCYC * CLKS_PER_MCYC);
	localparam logic [HOLD_W-1:0] POR_DELAY_CLKS_DEF = 8'h10;
	localparam logic [8:0] WDT_LAST_CNT = 9'(WDT_RESET_DELAY_CLKS - 1);
	localparam logic [1:0] PHASE_C4 = 2'h3;

	// Register byte offsets
	localparam logic [11:0] OFS_POWER_CONTROL = 12'h000;
	localparam logic [11:0] OFS_WATCHDOG_CONTROL = 12'h004;
	localparam logic [11:0] OFS_WAKE_CONFIG = 12'h008;
	localparam logic [11:0] OFS_STATUS = 12'h00C;

	// Field positions
	localparam int unsigned POWER_CONTROL_IDLE_BIT = 0;
	localparam int unsigned POWER_CONTROL_PD_BIT = 1;
	localparam int unsigned WATCHDOG_CONTROL_EWT_BIT = 1;
	localparam int unsigned WATCHDOG_CONTROL_WATCHDOG_RESET_FLAG_BIT = 2;
	localparam int unsigned WATCHDOG_CONTROL_WDIF_BIT = 3;
	localparam int unsigned WATCHDOG_CONTROL_POR_BIT = 6;
	localparam int unsigned WAKE_EN_LSB = 0;
	localparam int unsigned WAKE_GIE_BIT = 2;
	localparam int unsigned WAKE_LEVEL_LSB = 3;

	// Reset values handed to the core and to this block
	localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
	localparam logic [7:0] WATCHDOG_CONTROL_POR_VAL = 8'h40;
	localparam logic [7:0] SP_RESET = 8'h07;
	localparam logic [7:0] PMR_RESET = 8'h40;
	localparam logic [7:0] PORT_RESET = 8'hFF;
	localparam logic [15:0] PC_RESET = 16'h0000;

	// Operating modes, Gray coded along run, entry, power-down
	typedef enum logic [1:0] {
		MODE_RUN = 2'b00,
		MODE_PD_PEND = 2'b01,
		MODE_PD = 2'b11,
		MODE_IDLE = 2'b10
	} mode_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;

	typedef struct packed {
		logic ale;
		logic fetch_strobe;
		logic port0_float;
		logic port2_addr;
		logic port_hold;
	} pin_ctl_t;

	typedef struct packed {
		mode_t mode;
		logic [1:0] phase;
		logic rst_smp;
		logic [HOLD_W-1:0] hold;
		logic core_rst;
		logic clk_en;
		logic wdt_clk_en;
		logic [1:0] int_meta;
		logic [1:0] int_sync;
		logic [1:0] wake_irq;
		logic wd_act;
		logic [8:0] wd_cnt;
		logic [7:0] power_control;
		logic [7:0] watchdog_control;
		logic [4:0] wake_cfg;
		pin_ctl_t pins;
		apb_rsp_t apb;
	} ctl_state_t;

endpackage

/* rtl/power_down_and_reset_control.sv */
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module power_down_and_reset_control
	import pwr_rst_pkg::*;
#(
	parameter logic [HOLD_W-1:0] POR_DELAY_CLKS = POR_DELAY_CLKS_DEF
) (
	// Clock and power-on reset from the supply monitor
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	// Register bus
	input wire apb_req_t i_apb,
	output apb_rsp_t o_apb,
	// External pins
	input wire logic i_ext_reset,
	input wire logic [1:0] i_ext_int_n,
	input wire logic i_ext_prog_mem,
	// Core side strobes and wake request
	input wire logic i_core_ale,
	input wire logic i_core_fetch_strobe,
	input wire logic i_irq_request,
	// Watchdog counter side
	input wire logic i_wdt_timeout,
	input wire logic i_wdt_clear,
	// Control outputs
	output logic o_core_reset,
	output logic o_core_clk_en,
	output logic o_wdt_clk_en,
	output logic o_wdt_irq_flag,
	output logic o_wdt_reset_enable,
	output logic [1:0] o_wake_irq,
	output pin_ctl_t o_pins
);

	// Power-on state of the whole block
	localparam ctl_state_t RESET_STATE = '{
		mode: MODE_RUN,
		phase: 2'h0,
		rst_smp: 1'b0,
		hold: POR_DELAY_CLKS,
		core_rst: 1'b1,
		clk_en: 1'b1,
		wdt_clk_en: 1'b1,
		int_meta: 2'h0,
		int_sync: 2'h0,
		wake_irq: 2'h0,
		wd_act: 1'b0,
		wd_cnt: 9'h000,
		power_control: POWER_CONTROL_RESET,
		watchdog_control: WATCHDOG_CONTROL_POR_VAL,
		wake_cfg: 5'h00,
		pins: '{ale: 1'b0, fetch_strobe: 1'b0, port0_float: 1'b0, port2_addr: 1'b0,
			port_hold: 1'b0},
		apb: '{prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0}
	};

	ctl_state_t s;
	ctl_state_t n;
	logic c4;
	logic access;
	logic done;
	logic mapped;
	logic wake;
	logic wd_run;
	logic wd_fire;
	logic [31:0] rdata;

	// Bus decode and read mux
	always_comb begin
		access = i_apb.psel & i_apb.penable;
		done = access & s.apb.pready;
		mapped = 1'b1;
		rdata = 32'h0000_0000;
		case (i_apb.paddr)
			OFS_POWER_CONTROL: rdata = {24'h00_0000, s.power_control};
			OFS_WATCHDOG_CONTROL: rdata = {24'h00_0000, s.watchdog_control};
			OFS_WAKE_CONFIG: rdata = {27'h000_0000, s.wake_cfg};
			OFS_STATUS: rdata = {27'h000_0000, s.wd_act, s.core_rst, s.mode, s.clk_en};
			default: mapped = 1'b0;
		endcase
	end

	// Machine-cycle phase and wake condition
	always_comb begin
		c4 = (s.phase == PHASE_C4);
		wake = s.wake_cfg[WAKE_GIE_BIT] &
			|(s.int_sync & s.wake_cfg[WAKE_EN_LSB +: 2] & s.wake_cfg[WAKE_LEVEL_LSB +: 2]);
		wd_run = (s.mode != MODE_PD);
		wd_fire = wd_run & s.wd_act & ~i_wdt_clear & ~i_wdt_timeout & (s.wd_cnt == WDT_LAST_CNT) &
			s.watchdog_control[WATCHDOG_CONTROL_EWT_BIT];
	end

	// Next-state logic for the whole block
	always_comb begin
		n = s;
		n.phase = s.phase + 2'h1;
		n.wake_irq = 2'h0;
		n.apb.pready = access & ~s.apb.pready;
		n.apb.pslverr = 1'b0;
		n.apb.prdata = 32'h0000_0000;
		// Level wake path into this clock domain
		n.int_meta = ~i_ext_int_n;
		n.int_sync = s.int_meta;
		// Reset pin sampled once per machine cycle
		if (c4) begin
			n.rst_smp = i_ext_reset;
		end
		// Stretch after the pin falls
		if (s.rst_smp) begin
			n.hold = RST_STRETCH_CLKS;
		end else if (s.hold != '0) begin
			n.hold = s.hold - HOLD_W'(1);
		end
		// Register reads and writes
		if (access & ~s.apb.pready) begin
			n.apb.prdata = rdata;
			n.apb.pslverr = ~mapped;
		end
		if (done & i_apb.pwrite & mapped) begin
			case (i_apb.paddr)
				OFS_POWER_CONTROL: begin
					n.power_control = {6'h00, i_apb.pwdata[POWER_CONTROL_PD_BIT], i_apb.pwdata[POWER_CONTROL_IDLE_BIT]};
					if (i_apb.pwdata[POWER_CONTROL_PD_BIT]) begin
						n.mode = MODE_PD_PEND;
					end else if (i_apb.pwdata[POWER_CONTROL_IDLE_BIT]) begin
						n.mode = MODE_IDLE;
					end
				end
				OFS_WATCHDOG_CONTROL: begin
					// Flags clear on zero, enable is plain read-write
					n.watchdog_control[WATCHDOG_CONTROL_POR_BIT] = s.watchdog_control[WATCHDOG_CONTROL_POR_BIT] & i_apb.pwdata[WATCHDOG_CONTROL_POR_BIT];
					n.watchdog_control[WATCHDOG_CONTROL_WDIF_BIT] = s.watchdog_control[WATCHDOG_CONTROL_WDIF_BIT] & i_apb.pwdata[WATCHDOG_CONTROL_WDIF_BIT];
					n.watchdog_control[WATCHDOG_CONTROL_WATCHDOG_RESET_FLAG_BIT] = s.watchdog_control[WATCHDOG_CONTROL_WATCHDOG_RESET_FLAG_BIT] & i_apb.pwdata[WATCHDOG_CONTROL_WATCHDOG_RESET_FLAG_BIT];
					n.watchdog_control[WATCHDOG_CONTROL_EWT_BIT] = i_apb.pwdata[WATCHDOG_CONTROL_EWT_BIT];
				end
				OFS_WAKE_CONFIG: n.wake_cfg = i_apb.pwdata[4:0];
				default: n.wake_cfg = s.wake_cfg;
			endcase
		end
		// Watchdog time-out and delayed reset, frozen while clocks stop
		if (wd_run) begin
			if (i_wdt_clear) begin
				n.wd_act = 1'b0;
				n.wd_cnt = 9'h000;
			end else if (i_wdt_timeout) begin
				n.watchdog_control[WATCHDOG_CONTROL_WDIF_BIT] = 1'b1;
				n.wd_act = 1'b1;
				n.wd_cnt = 9'h000;
			end else if (wd_fire) begin
				n.wd_act = 1'b0;
				n.wd_cnt = 9'h000;
				n.watchdog_control[WATCHDOG_CONTROL_WATCHDOG_RESET_FLAG_BIT] = 1'b1;
				n.hold = WDT_HOLD_CLKS;
			end else if (s.wd_act) begin
				n.wd_cnt = s.wd_cnt + 9'h001;
			end
		end
		// Mode sequencing
		case (s.mode)
			MODE_RUN: n.wake_irq = 2'h0;
			MODE_PD_PEND: begin
				if (c4) begin
					n.mode = MODE_PD;
				end
			end
			MODE_PD: begin
				if (wake) begin
					n.mode = MODE_RUN;
					n.power_control[POWER_CONTROL_PD_BIT] = 1'b0;
					n.wake_irq = s.int_sync & s.wake_cfg[WAKE_EN_LSB +: 2];
				end
			end
			MODE_IDLE: begin
				if (i_irq_request) begin
					n.mode = MODE_RUN;
					n.power_control[POWER_CONTROL_IDLE_BIT] = 1'b0;
				end
			end
			default: n.mode = MODE_RUN;
		endcase
		// External or watchdog reset returns to run from reset vector
		n.core_rst = n.rst_smp | (n.hold != '0);
		if (n.core_rst) begin
			n.mode = MODE_RUN;
			n.power_control = POWER_CONTROL_RESET;
			n.watchdog_control[WATCHDOG_CONTROL_WDIF_BIT] = 1'b0;
			n.wake_irq = 2'h0;
		end
		// Clock gates and pin states follow the next mode
		n.clk_en = (n.mode != MODE_PD);
		n.wdt_clk_en = (n.mode != MODE_PD);
		case (n.mode)
			MODE_IDLE: begin
				n.pins.ale = 1'b1;
				n.pins.fetch_strobe = 1'b1;
				n.pins.port0_float = i_ext_prog_mem;
				n.pins.port2_addr = i_ext_prog_mem;
				n.pins.port_hold = 1'b1;
			end
			MODE_PD: begin
				n.pins.ale = 1'b0;
				n.pins.fetch_strobe = 1'b0;
				n.pins.port0_float = i_ext_prog_mem;
				n.pins.port2_addr = 1'b0;
				n.pins.port_hold = 1'b1;
			end
			default: begin
				n.pins.ale = i_core_ale;
				n.pins.fetch_strobe = i_core_fetch_strobe;
				n.pins.port0_float = 1'b0;
				n.pins.port2_addr = 1'b0;
				n.pins.port_hold = 1'b0;
			end
		endcase
	end

	// State register; supply-monitor reset reloads power-on values
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			s <= RESET_STATE;
		end else begin
			s <= n;
		end
	end

	// Outputs straight from the state register
	always_comb begin
		o_apb = s.apb;
		o_core_reset = s.core_rst;
		o_core_clk_en = s.clk_en;
		o_wdt_clk_en = s.wdt_clk_en;
		o_wdt_irq_flag = s.watchdog_control[WATCHDOG_CONTROL_WDIF_BIT];
		o_wdt_reset_enable = s.watchdog_control[WATCHDOG_CONTROL_EWT_BIT];
		o_wake_irq = s.wake_irq;
		o_pins = s.pins;
	end

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_resetn);

	// Power-down entered at the end of the machine cycle
	a_pd_entry_c4: assert property (
		(s.mode == MODE_PD_PEND && c4 && !n.core_rst) |=> (s.mode == MODE_PD) && !o_core_clk_en
	) else $error("power-down not entered at C4");

	// No clock runs in power-down
	a_pd_clocks_off: assert property (
		(s.mode == MODE_PD) |-> (!o_core_clk_en && !o_wdt_clk_en)
	) else $error("clock enabled in power-down");

	// Strobes low and ports held in power-down
	a_pd_pin_state: assert property (
		(s.mode == MODE_PD) |-> (!o_pins.ale && !o_pins.fetch_strobe && o_pins.port_hold)
	) else $error("pin state wrong in power-down");

	// Reset pin ends power-down
	a_pd_reset_exit: assert property (
		(s.mode == MODE_PD && c4 && i_ext_reset) |=> (s.mode == MODE_RUN) && o_core_reset
	) else $error("reset pin did not end power-down");

	// Watchdog does not advance in power-down
	a_wdt_frozen_pd: assert property (
		(s.mode == MODE_PD) |=> $stable(s.wd_cnt)
	) else $error("watchdog advanced in power-down");

	// Level interrupt wakes with a pulse
	a_level_wake: assert property (
		(s.mode == MODE_PD && wake && !n.core_rst) |=> (s.mode == MODE_RUN) && (o_wake_irq != 2'h0)
	) else $error("level wake not taken");

	// Strobes high in idle
	a_idle_strobes: assert property (
		(s.mode == MODE_IDLE) |-> (o_pins.ale && o_pins.fetch_strobe)
	) else $error("strobes not high in idle");

	// Pin sample at C4 puts the core in reset next cycle
	a_pin_sample_c4: assert property (
		(c4 && i_ext_reset) |=> (s.rst_smp && o_core_reset)
	) else $error("reset pin not sampled at C4");

	// Reset stretched two machine cycles after pin release
	a_rst_stretch: assert property (
		$fell(s.rst_smp) |-> o_core_reset [*8]
	) else $error("reset stretch too short");

	// Watchdog expiry with enable gives a flagged reset
	a_wdt_reset: assert property (
		wd_fire |=> (s.watchdog_control[WATCHDOG_CONTROL_WATCHDOG_RESET_FLAG_BIT] && o_core_reset && s.hold == WDT_HOLD_CLKS)
	) else $error("watchdog reset not issued");

	// Power-on leaves source flags and enable at known values
	a_por_flags: assert property (
		$rose(i_resetn) |-> (s.watchdog_control == WATCHDOG_CONTROL_POR_VAL && o_core_reset)
	) else $error("power-on flags wrong");

endmodule // power_down_and_reset_control

`default_nettype wire

/* testbench/board_stub.sv */
`timescale 1ns/1ps
`default_nettype none
module board_stub (
	// Clock
	input wire logic i_clk,
	// Board pins
	output logic o_ext_reset,
	output logic [1:0] o_ext_int_n
);
	// Pins rest at their pull levels
	initial begin
		o_ext_reset = 1'b0;
		o_ext_int_n = 2'b11;
	end
	// Push button: pin high for n clocks
	task automatic press_reset(input int n);
		@(posedge i_clk);
		o_ext_reset <= 1'b1;
		repeat (n) @(posedge i_clk);
		o_ext_reset <= 1'b0;
	endtask
	// Level source: pin low for n clocks
	task automatic pull_int(input int idx, input int n);
		@(posedge i_clk);
		o_ext_int_n[idx] <= 1'b0;
		repeat (n) @(posedge i_clk);
		o_ext_int_n[idx] <= 1'b1;
	endtask
endmodule // board_stub
`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import pwr_rst_pkg::*;
	typedef struct {logic wr; logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} row_t;
	logic clk, rstn, ext_rst, pmem, ale, fs, irq, wto, wclr, crst, cen, wen, wflag, wren, err;
	logic [1:0] int_n, wake, wake_seen;
	logic [31:0] rd;
	apb_req_t req;
	apb_rsp_t rsp;
	pin_ctl_t pins;
	int error_cnt, checks_done, cyc, rises, n, r0;
	row_t rows[10];
	power_down_and_reset_control #(.POR_DELAY_CLKS(8'h04)) u_dut (
		.i_ref_clk(clk), .i_resetn(rstn), .i_apb(req), .o_apb(rsp), .i_ext_reset(ext_rst),
		.i_ext_int_n(int_n), .i_ext_prog_mem(pmem), .i_core_ale(ale), .i_core_fetch_strobe(fs),
		.i_irq_request(irq), .i_wdt_timeout(wto), .i_wdt_clear(wclr), .o_core_reset(crst),
		.o_core_clk_en(cen), .o_wdt_clk_en(wen), .o_wdt_irq_flag(wflag),
		.o_wdt_reset_enable(wren), .o_wake_irq(wake), .o_pins(pins));
	board_stub u_board (.i_clk(clk), .o_ext_reset(ext_rst), .o_ext_int_n(int_n));
	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Watchers and hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (wake != 2'b00) wake_seen <= wake;
		if ($rose(crst)) rises <= rises + 1;
		if (cyc == 8000) begin
			error_cnt++;
			stop_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("BAD %s exp %h got %h", nm, exp, got);
			error_cnt++;
		end
	endtask
	// One APB transfer, waits for pready
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge clk);
		req.penable <= 1'b1;
		do @(posedge clk); while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	// Bounded wait: 0 core reset, 1 clock enable, 2 watchdog flag
	task automatic wait_sig(input int w, input logic v, input int lim);
		logic s;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			s = (w == 0) ? crst : (w == 1) ? cen : wflag;
		end while (s !== v && n < lim);
		if (s !== v) chk("wait", 32'(v), 32'(s));
	endtask
	task automatic pulse(input logic clr);
		@(posedge clk);
		if (clr) wclr <= 1'b1;
		else wto <= 1'b1;
		@(posedge clk);
		wclr <= 1'b0;
		wto <= 1'b0;
	endtask
	task automatic done(input string nm);
		$display("test %s done", nm);
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Main sequence
	initial begin
		{ale, fs, irq, wto, wclr, rstn} = '0;
		{pmem, cyc, rises, error_cnt, checks_done, wake_seen} = '0;
		pmem = 1'b1;
		req = '0;
		rows = '{'{1'b0, OFS_POWER_CONTROL, 32'h0, 32'(POWER_CONTROL_RESET), 1'b0},
			'{1'b0, OFS_WATCHDOG_CONTROL, 32'h0, 32'h40, 1'b0},
			'{1'b0, 12'h010, 32'h0, 32'h0, 1'b1},
			'{1'b1, OFS_WATCHDOG_CONTROL, 32'h42, 32'h0, 1'b0},
			'{1'b0, OFS_WATCHDOG_CONTROL, 32'h0, 32'h42, 1'b0},
			'{1'b1, OFS_WAKE_CONFIG, 32'h0D, 32'h0, 1'b0},
			'{1'b0, OFS_WAKE_CONFIG, 32'h0, 32'h0D, 1'b0},
			'{1'b1, 12'h010, 32'h0F, 32'h0, 1'b1},
			'{1'b1, OFS_WATCHDOG_CONTROL, 32'h02, 32'h0, 1'b0},
			'{1'b0, OFS_WATCHDOG_CONTROL, 32'h0, 32'h02, 1'b0}};
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		wait_sig(0, 1'b0, 40);
		foreach (rows[i]) begin
			apb(rows[i].wr, rows[i].a, rows[i].d);
			if (!rows[i].wr) chk("rdata", rows[i].q, rd);
			chk("pslverr", 32'(rows[i].e), 32'(err));
		end
		done("registers");
		// External reset: no source flag, enable kept
		u_board.press_reset(8);
		chk("ext rst", 32'h1, 32'(crst));
		wait_sig(0, 1'b0, 14);
		apb(1'b0, OFS_WATCHDOG_CONTROL, 32'h0);
		chk("watchdog_control ext", 32'h02, rd);
		done("ext reset");
		// Watchdog time-out then reset 512 clocks later
		pulse(1'b0);
		wait_sig(2, 1'b1, 3);
		wait_sig(0, 1'b1, 600);
		chk("wdt delay", 32'd512, n);
		wait_sig(0, 1'b0, 20);
		chk("wdt hold", 32'd8, n);
		apb(1'b0, OFS_WATCHDOG_CONTROL, 32'h0);
		chk("watchdog_control wdt", 32'h06, rd);
		done("wdt reset");
		// Cleared watchdog never resets
		apb(1'b1, OFS_WATCHDOG_CONTROL, 32'h02);
		pulse(1'b0);
		repeat (100) @(posedge clk);
		r0 = rises;
		pulse(1'b1);
		repeat (600) @(posedge clk);
		chk("wdt cleared", r0, rises);
		apb(1'b1, OFS_WATCHDOG_CONTROL, 32'h02);
		done("wdt clear");
		// Power-down entry, frozen watchdog, level wake
		{ale, fs} <= 2'b11;
		apb(1'b1, OFS_WAKE_CONFIG, 32'h0D);
		apb(1'b1, OFS_POWER_CONTROL, 32'h02);
		wait_sig(1, 1'b0, 12);
		chk("pd pins", 32'h05, 32'(pins));
		chk("pd wdt clk", 32'h0, 32'(wen));
		pulse(1'b0);
		repeat (4) @(posedge clk);
		chk("pd wdt flag", 32'h0, 32'(wflag));
		u_board.pull_int(0, 6);
		chk("wake", 32'h1, 32'(wake_seen));
		wait_sig(1, 1'b1, 12);
		done("power-down");
		// Idle strobes high, left by an interrupt
		{ale, fs} <= 2'b00;
		apb(1'b1, OFS_POWER_CONTROL, 32'h01);
		repeat (3) @(posedge clk);
		chk("idle pins", 32'h0F, 32'(pins[4:1]));
		irq <= 1'b1;
		repeat (3) @(posedge clk);
		irq <= 1'b0;
		apb(1'b0, OFS_STATUS, 32'h0);
		chk("idle exit", 32'h01, rd);
		done("idle");
		// Reset pin ends power-down
		apb(1'b1, OFS_POWER_CONTROL, 32'h02);
		wait_sig(1, 1'b0, 12);
		u_board.press_reset(8);
		wait_sig(0, 1'b0, 14);
		chk("pd exit clk", 32'h1, 32'(cen));
		done("pd reset");
		// Supply loss repeats power-on reset
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		wait_sig(0, 1'b0, 40);
		apb(1'b0, OFS_WATCHDOG_CONTROL, 32'h0);
		chk("watchdog_control por", 32'h40, rd);
		chk("wdt en por", 32'h0, 32'(wren));
		done("power-on");
		stop_test();
	end
endmodule // tb
`default_nettype wire
